// *** fmd_motion_detect.sv ***
// Freefall and motion detector with its configuration, source and threshold registers.
`timescale 1ns/1ps

module fmd_motion_detect #(
    parameter int SAMPLE_W = fmd_pkg::SAMPLE_W,
    parameter int COUNT_W  = fmd_pkg::COUNT_W
) (
    // Clock and reset.
    input  wire logic                           clk_sys_in,
    input  wire logic                           sys_rst_in,
    // New acceleration sample, one-cycle strobe at the output data rate.
    input  wire logic                           sample_valid_in,
    input  wire logic signed [SAMPLE_W-1:0]     x_sample_in,
    input  wire logic signed [SAMPLE_W-1:0]     y_sample_in,
    input  wire logic signed [SAMPLE_W-1:0]     z_sample_in,
    // Settings held elsewhere in the device.
    input  wire logic        [COUNT_W-1:0]      debounce_count_in,
    input  wire logic                           motion_irq_enable_in,
    input  wire logic                           motion_irq_route_in,
    // Register port.
    input  wire logic        [fmd_pkg::REG_W-1:0] reg_addr_in,
    input  wire logic                           reg_wr_in,
    input  wire logic        [fmd_pkg::REG_W-1:0] reg_wdata_in,
    input  wire logic                           reg_rd_in,
    output logic             [fmd_pkg::REG_W-1:0] reg_rdata_out,
    output logic                            reg_rvalid_out,
    // Status and interrupt lines.
    output logic                            event_active_out,
    output logic                            irq_line1_out,
    output logic                            irq_line2_out
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State and its next value.
    fmd_pkg::fmd_state_t state_ff;
    fmd_pkg::fmd_state_t nxt_state;

    // Decoded configuration fields.
    logic                           latch_events;
    logic                           combine_select;
    logic [fmd_pkg::AXES-1:0]       axis_enable;
    logic                           debounce_mode;
    logic [fmd_pkg::THS_W-1:0]      threshold_value;

    // Per-axis comparison results, index 0 is X, 1 is Y, 2 is Z.
    logic [fmd_pkg::AXES-1:0]       axis_high;
    logic [fmd_pkg::AXES-1:0]       axis_low;
    logic [fmd_pkg::AXES-1:0]       axis_neg;

    // Combined condition and live flag image.
    logic                           any_enabled;
    logic                           motion_cond;
    logic                           freefall_cond;
    logic                           qualify;
    logic [fmd_pkg::FLAG_W-1:0]     live_flags;
    logic [fmd_pkg::FLAG_W-1:0]     enable_mask;

    // Register access decode.
    logic                           wr_config;
    logic                           wr_threshold;
    logic                           rd_source;
    logic                           latched_clear;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Field extraction from the stored configuration.
    assign latch_events    = state_ff.config_reg[fmd_pkg::CFG_LATCH_BIT];
    assign combine_select  = state_ff.config_reg[fmd_pkg::CFG_COMBINE_BIT];
    assign axis_enable     = state_ff.config_reg[fmd_pkg::CFG_EN_LSB +: fmd_pkg::AXES];

    assign debounce_mode   = state_ff.threshold_reg[fmd_pkg::THS_MODE_BIT];
    assign threshold_value = state_ff.threshold_reg[fmd_pkg::THS_VALUE_LSB +: fmd_pkg::THS_W];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // One comparator per axis; the threshold is shared.
    fmd_axis_cmp #(
        .SAMPLE_W (SAMPLE_W)
    ) u_cmp_x (
        .sample_in (x_sample_in),
        .thresh_in (threshold_value),
        .high_out  (axis_high[0]),
        .low_out   (axis_low[0]),
        .neg_out   (axis_neg[0])
    );

    fmd_axis_cmp #(
        .SAMPLE_W (SAMPLE_W)
    ) u_cmp_y (
        .sample_in (y_sample_in),
        .thresh_in (threshold_value),
        .high_out  (axis_high[1]),
        .low_out   (axis_low[1]),
        .neg_out   (axis_neg[1])
    );

    fmd_axis_cmp #(
        .SAMPLE_W (SAMPLE_W)
    ) u_cmp_z (
        .sample_in (z_sample_in),
        .thresh_in (threshold_value),
        .high_out  (axis_high[2]),
        .low_out   (axis_low[2]),
        .neg_out   (axis_neg[2])
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Combination of the enabled axes.
    // Disabled axes are left out of the AND, otherwise freefall could never fire with
    // fewer than three axes enabled.
    // Without this guard an empty AND would read as freefall.
    assign any_enabled   = |axis_enable;
    assign motion_cond   = |(axis_high & axis_enable);
    assign freefall_cond = &(axis_low | ~axis_enable);
    assign qualify       = any_enabled
                           && (combine_select ? motion_cond : freefall_cond);

    // Live flag image: pairs of high flag and polarity, X in the low pair.
    always_comb
    begin
        live_flags  = fmd_pkg::FLAGS_CLEAR;
        enable_mask = fmd_pkg::FLAGS_CLEAR;

        for (int i = 0; i < fmd_pkg::AXES; i++)
        begin
            live_flags[2*i+1]  = axis_enable[i] & axis_high[i];
            // A quiet axis reports positive polarity.
            live_flags[2*i]    = axis_enable[i] & axis_high[i] & axis_neg[i];
            enable_mask[2*i+1] = axis_enable[i];
            enable_mask[2*i]   = axis_enable[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register access decode.
    assign wr_config     = reg_wr_in && (reg_addr_in == fmd_pkg::REG_CONFIG_ADDR);
    assign wr_threshold  = reg_wr_in && (reg_addr_in == fmd_pkg::REG_THRESHOLD_ADDR);
    assign rd_source     = reg_rd_in && (reg_addr_in == fmd_pkg::REG_SOURCE_ADDR);

    // Only a latched source read has a side effect.
    assign latched_clear = rd_source && latch_events;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    // A latched source read clears first and the sample of the same cycle is then
    // applied to the cleared state, so an event landing on the read is not lost.
    always_comb
    begin
        logic [COUNT_W-1:0] cnt;
        logic               active;
        logic [fmd_pkg::FLAG_W-1:0] flags;
        logic               reached;

        // Working copies keep the clear-then-sample order.
        cnt       = state_ff.debounce_cnt;
        active    = state_ff.event_active;
        flags     = state_ff.flags;
        reached   = 1'b0;
        nxt_state = state_ff;

        // Register writes; the source register is read-only.
        if (wr_config)
        begin
            nxt_state.config_reg = reg_wdata_in;
        end

        if (wr_threshold)
        begin
            nxt_state.threshold_reg = reg_wdata_in;
        end

        // Read data is captured before the clear takes effect; disabled pairs read zero.
        nxt_state.rvalid = reg_rd_in;

        if (reg_rd_in)
        begin
            case (reg_addr_in)
                fmd_pkg::REG_CONFIG_ADDR:
                begin
                    nxt_state.rdata = state_ff.config_reg;
                end

                fmd_pkg::REG_SOURCE_ADDR:
                begin
                    nxt_state.rdata = fmd_pkg::READ_ZERO;
                    nxt_state.rdata[fmd_pkg::SRC_ACTIVE_BIT] = state_ff.event_active;
                    nxt_state.rdata[fmd_pkg::SRC_FLAG_LSB +: fmd_pkg::FLAG_W] =
                        state_ff.flags & enable_mask;
                end

                fmd_pkg::REG_THRESHOLD_ADDR:
                begin
                    nxt_state.rdata = state_ff.threshold_reg;
                end

                default:
                begin
                    // Unmapped offsets answer zero.
                    nxt_state.rdata = fmd_pkg::READ_ZERO;
                end
            endcase
        end

        // Latched read clears event_active, every flag and the debounce counter.
        if (latched_clear)
        begin
            cnt    = fmd_pkg::COUNT_ZERO;
            active = 1'b0;
            flags  = fmd_pkg::FLAGS_CLEAR;
        end

        // Detection runs only on a new sample.
        if (sample_valid_in)
        begin
            // Debounce counter.
            // Clear mode restarts; decrement mode rides out gaps.
            if (qualify)
            begin
                if (cnt < debounce_count_in)
                begin
                    cnt = cnt + fmd_pkg::COUNT_ONE;
                end
                else
                begin
                    cnt = debounce_count_in;
                end
            end
            else if (debounce_mode)
            begin
                cnt = fmd_pkg::COUNT_ZERO;
            end
            else if (cnt != fmd_pkg::COUNT_ZERO)
            begin
                cnt = cnt - fmd_pkg::COUNT_ONE;
            end

            // Count zero sets on the first hit.
            reached = qualify && (cnt == debounce_count_in);

            if (latch_events)
            begin
                // Sticky until read; flags follow live status only while inactive.
                if (!active)
                begin
                    flags = live_flags;
                    if (reached)
                    begin
                        active = 1'b1;
                    end
                end
            end
            else
            begin
                // Unlatched: set on reaching the count, cleared once the counter drains.
                flags = live_flags;
                if (reached)
                begin
                    active = 1'b1;
                end
                else if (cnt == fmd_pkg::COUNT_ZERO)
                begin
                    active = 1'b0;
                end
            end
        end

        // Turning every axis off stops the function and drops any pending event.
        if (!any_enabled)
        begin
            cnt    = fmd_pkg::COUNT_ZERO;
            active = 1'b0;
            flags  = fmd_pkg::FLAGS_CLEAR;
        end

        nxt_state.debounce_cnt = cnt;
        nxt_state.event_active = active;
        nxt_state.flags        = flags;

        // Interrupt lines follow the stored event, gated and steered by the settings.
        nxt_state.irq_line1 = state_ff.event_active
                              && motion_irq_enable_in && motion_irq_route_in;

        nxt_state.irq_line2 = state_ff.event_active
                              && motion_irq_enable_in && !motion_irq_route_in;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State register; configuration starts as latch off, freefall, all axes off.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_ff.config_reg    <= fmd_pkg::CONFIG_RST;
            state_ff.threshold_reg <= fmd_pkg::THRESHOLD_RST;
            state_ff.debounce_cnt  <= fmd_pkg::COUNT_ZERO;
            state_ff.event_active  <= 1'b0;
            state_ff.flags         <= fmd_pkg::FLAGS_CLEAR;

            state_ff.rdata         <= fmd_pkg::READ_ZERO;
            state_ff.rvalid        <= 1'b0;
            state_ff.irq_line1     <= 1'b0;
            state_ff.irq_line2     <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    // No output is decoded, so pins never glitch.
    assign reg_rdata_out    = state_ff.rdata;
    assign reg_rvalid_out   = state_ff.rvalid;
    assign event_active_out = state_ff.event_active;
    assign irq_line1_out    = state_ff.irq_line1;
    assign irq_line2_out    = state_ff.irq_line2;

endmodule : fmd_motion_detect

// *** fmd_pkg.sv ***
// Package with register map, field layout, reset values and types of the freefall/motion block.
package fmd_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register offsets on the device register port.
    localparam logic [7:0] REG_CONFIG_ADDR    = 8'h15;
    localparam logic [7:0] REG_SOURCE_ADDR    = 8'h16;
    localparam logic [7:0] REG_THRESHOLD_ADDR = 8'h17;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int REG_W       = 8;
    localparam int AXES        = 3;
    localparam int THS_W       = 7;
    localparam int SAMPLE_W    = 12;
    localparam int COUNT_W     = 8;
    localparam int FLAG_W      = 2 * AXES;

    // Configuration register field positions.
    localparam int CFG_LATCH_BIT  = 7;
    localparam int CFG_COMBINE_BIT = 6;
    localparam int CFG_EN_LSB     = 3;

    // Source register field positions; each axis owns a flag and polarity pair.
    localparam int SRC_ACTIVE_BIT = 7;
    localparam int SRC_FLAG_LSB   = 0;

    // Threshold register field positions.
    localparam int THS_MODE_BIT   = 7;
    localparam int THS_VALUE_LSB  = 0;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [REG_W-1:0]   CONFIG_RST    = 8'h00;
    localparam logic [REG_W-1:0]   THRESHOLD_RST = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ZERO    = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE     = 8'h01;
    localparam logic [FLAG_W-1:0]  FLAGS_CLEAR   = 6'h00;
    localparam logic [REG_W-1:0]   READ_ZERO     = 8'h00;

    // Threshold scale: one step is 0.063 g, full comparison range is 8 g.
    localparam int THS_STEP_MILLI_G = 63;
    localparam int FULL_SCALE_G     = 8;
    // Samples arrive on the 8 g scale; dropping the low bits gives threshold steps.
    localparam int SAMPLE_SHIFT     = SAMPLE_W - 1 - THS_W;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Complete state of the top module.
    typedef struct packed {
        logic [REG_W-1:0]   config_reg;
        logic [REG_W-1:0]   threshold_reg;
        logic [COUNT_W-1:0] debounce_cnt;
        logic               event_active;
        logic [FLAG_W-1:0]  flags;
        logic [REG_W-1:0]   rdata;
        logic               rvalid;
        logic               irq_line1;
        logic               irq_line2;
    } fmd_state_t;

endpackage : fmd_pkg

// *** fmd_axis_cmp.sv ***
// One axis comparator: magnitude of a signed sample against the 7-bit threshold.
`timescale 1ns/1ps

module fmd_axis_cmp #(
    parameter int SAMPLE_W = fmd_pkg::SAMPLE_W,
    parameter int THS_W    = fmd_pkg::THS_W,
    parameter int SHIFT    = fmd_pkg::SAMPLE_SHIFT
) (
    // Sample and threshold.
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    input  wire logic        [THS_W-1:0]    thresh_in,
    // Comparison results.
    output logic                            high_out,
    output logic                            low_out,
    output logic                            neg_out
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    logic [SAMPLE_W-1:0] magnitude;
    logic [THS_W:0]      coarse;

    // Magnitude fits unsigned in the sample width, even for the most negative code.
    assign magnitude = sample_in[SAMPLE_W-1] ? SAMPLE_W'(-sample_in) : SAMPLE_W'(sample_in);

    // Coarse value reaches one step above the threshold range, so 8 g is still seen.
    assign coarse = (THS_W+1)'(magnitude >> SHIFT);

    // Strictly above for motion, at or below for the low condition.
    assign high_out = coarse > {1'b0, thresh_in};
    assign low_out  = coarse <= {1'b0, thresh_in};
    assign neg_out  = sample_in[SAMPLE_W-1];

endmodule : fmd_axis_cmp

// *** fmd_host_model.sv ***
// Host model that reaches the detector registers through its strobe port.
`timescale 1ns/1ps

module fmd_host_model (
    // Clock.
    input  wire logic       clk_sys_in,
    // Register port requests.
    output logic      [7:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_rd_out,
    // Register port answers.
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle port at time zero.
    initial
    begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out    = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr_out    = 1'b0;
        reg_addr_out  = ~a;
        reg_wdata_out = ~d;
        @(posedge clk_sys_in);
        #1;
    endtask : reg_write

    // Read data is taken one cycle after the strobe, where it stands.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic v);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_rd_out   = 1'b0;
        reg_addr_out = ~a;
        v            = reg_rvalid_in;
        d            = reg_rdata_in;
        @(posedge clk_sys_in);
        #1;
    endtask : reg_read
endmodule : fmd_host_model

// *** fmd_motion_detect_monitor.sv ***
// Checker of the detector port behaviour.
`timescale 1ns/1ps

module fmd_motion_detect_monitor #(
    parameter int SAMPLE_W = fmd_pkg::SAMPLE_W,
    parameter int COUNT_W  = fmd_pkg::COUNT_W
) (
    // Every port of the detector.
    input wire logic                      clk_sys_in,
    input wire logic                      sys_rst_in,
    input wire logic                      sample_valid_in,
    input wire logic signed [SAMPLE_W-1:0] x_sample_in,
    input wire logic signed [SAMPLE_W-1:0] y_sample_in,
    input wire logic signed [SAMPLE_W-1:0] z_sample_in,
    input wire logic        [COUNT_W-1:0] debounce_count_in,
    input wire logic                      motion_irq_enable_in,
    input wire logic                      motion_irq_route_in,
    input wire logic        [7:0]         reg_addr_in,
    input wire logic                      reg_wr_in,
    input wire logic        [7:0]         reg_wdata_in,
    input wire logic                      reg_rd_in,
    input wire logic        [7:0]         reg_rdata_out,
    input wire logic                      reg_rvalid_out,
    input wire logic                      event_active_out,
    input wire logic                      irq_line1_out,
    input wire logic                      irq_line2_out
);
    logic [2:0] en_ff;
    logic       latch_ff;
    logic [5:0] allow;
    logic       src_rd;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the configuration, since the checker sees only ports.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            en_ff    <= 3'h0;
            latch_ff <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == 8'h15)
        begin
            en_ff    <= reg_wdata_in[5:3];
            latch_ff <= reg_wdata_in[7];
        end
    end

    // Source bits that an enabled axis may set.
    assign allow  = {{2{en_ff[2]}}, {2{en_ff[1]}}, {2{en_ff[0]}}};
    assign src_rd = reg_rd_in && reg_addr_in == 8'h16;

    ////////////////////////////////////////////////////////////////////////////////
    a_rvalid_follows_read: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read answer missing");
    a_rvalid_has_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("read answer without request");
    a_src_active_bit: assert property (reg_rvalid_out && $past(src_rd)
        |-> reg_rdata_out[7] == $past(event_active_out))
        else $error("source bit 7 differs from event active");
    a_src_axis_masked: assert property (reg_rvalid_out && $past(src_rd)
        |-> (reg_rdata_out[6:0] & ~{1'b0, $past(allow)}) == 7'h00)
        else $error("disabled axis bits set in source");
    a_irq_line_one: assert property (irq_line1_out ==
        $past(event_active_out && motion_irq_enable_in && motion_irq_route_in))
        else $error("first interrupt line wrong");
    a_irq_line_two: assert property (irq_line2_out ==
        $past(event_active_out && motion_irq_enable_in && !motion_irq_route_in))
        else $error("second interrupt line wrong");
    a_disabled_stays_quiet: assert property (en_ff == 3'h0 |=> !event_active_out)
        else $error("event active with all axes disabled");
    a_event_on_sample: assert property ($rose(event_active_out) |-> $past(sample_valid_in))
        else $error("event active rose without a sample");
    a_latched_read_clears: assert property (latch_ff && src_rd && !sample_valid_in
        |=> !event_active_out)
        else $error("latched source read did not clear");
    a_unlatched_read_keeps: assert property (!latch_ff && en_ff != 3'h0 && src_rd
        && event_active_out && !sample_valid_in && !reg_wr_in |=> event_active_out)
        else $error("unlatched source read cleared event");
endmodule : fmd_motion_detect_monitor

bind fmd_motion_detect fmd_motion_detect_monitor #(
    .SAMPLE_W(SAMPLE_W),
    .COUNT_W (COUNT_W)
) fmd_motion_detect_monitor_i (
    .clk_sys_in          (clk_sys_in),
    .sys_rst_in          (sys_rst_in),
    .sample_valid_in     (sample_valid_in),
    .x_sample_in         (x_sample_in),
    .y_sample_in         (y_sample_in),
    .z_sample_in         (z_sample_in),
    .debounce_count_in   (debounce_count_in),
    .motion_irq_enable_in(motion_irq_enable_in),
    .motion_irq_route_in (motion_irq_route_in),
    .reg_addr_in         (reg_addr_in),
    .reg_wr_in           (reg_wr_in),
    .reg_wdata_in        (reg_wdata_in),
    .reg_rd_in           (reg_rd_in),
    .reg_rdata_out       (reg_rdata_out),
    .reg_rvalid_out      (reg_rvalid_out),
    .event_active_out    (event_active_out),
    .irq_line1_out       (irq_line1_out),
    .irq_line2_out       (irq_line2_out)
);

// *** test_freefall_motion_detector.sv ***
// Self-checking testbench of the freefall/motion detector.
`timescale 1ns/1ps

module test_freefall_motion_detector;
    logic                     clk_sys_in, sys_rst_in, sample_valid_in, irq_en, irq_route;
    logic signed [11:0]       x_s, y_s, z_s;
    logic        [7:0]        dcount, addr_w, wdata_w, rdata_w;
    logic                     wr_w, rd_w, rvalid_w, ea_w, irq1_w, irq2_w;
    int                       error_cnt, n_compared, cycles;

    fmd_motion_detect fmd_motion_detect_i (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .sample_valid_in(sample_valid_in),
        .x_sample_in(x_s), .y_sample_in(y_s), .z_sample_in(z_s),
        .debounce_count_in(dcount), .motion_irq_enable_in(irq_en),
        .motion_irq_route_in(irq_route), .reg_addr_in(addr_w), .reg_wr_in(wr_w),
        .reg_wdata_in(wdata_w), .reg_rd_in(rd_w), .reg_rdata_out(rdata_w),
        .reg_rvalid_out(rvalid_w), .event_active_out(ea_w),
        .irq_line1_out(irq1_w), .irq_line2_out(irq2_w));

    fmd_host_model fmd_host_model_i (
        .clk_sys_in(clk_sys_in), .reg_addr_out(addr_w), .reg_wr_out(wr_w),
        .reg_wdata_out(wdata_w), .reg_rd_out(rd_w), .reg_rdata_in(rdata_w),
        .reg_rvalid_in(rvalid_w));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // A hang is cut short long after the sequence should have ended.
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : check

    // One sample strobe; the status is settled when the task returns.
    task automatic sample(input logic signed [11:0] x, y, z);
        x_s = x;
        y_s = y;
        z_s = z;
        sample_valid_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        sample_valid_in = 1'b0;
        x_s = ~x;
        y_s = ~y;
        z_s = ~z;
        @(posedge clk_sys_in);
        #1;
    endtask : sample

    task automatic ea_is(input logic e);
        check("event_active", {7'h00, e}, {7'h00, ea_w});
    endtask : ea_is

    task automatic rd_is(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        fmd_host_model_i.reg_read(a, d, v);
        check("rvalid", 8'h01, {7'h00, v});
        check("rdata", e, d);
    endtask : rd_is

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        fmd_host_model_i.reg_write(a, d);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; threshold 10 means magnitudes of 176 and above are high.
    initial
    begin
        {sys_rst_in, sample_valid_in, irq_en, irq_route} = 4'b1011;
        {x_s, y_s, z_s, dcount} = '0;
        {error_cnt, n_compared, cycles} = '0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        sys_rst_in = 1'b0;
        rd_is(8'h15, 8'h00);
        rd_is(8'h16, 8'h00);
        rd_is(8'h17, 8'h00);
        rd_is(8'h2a, 8'h00);
        wr(8'h15, 8'hff);
        rd_is(8'h15, 8'hff);
        wr(8'h16, 8'h55);
        rd_is(8'h16, 8'h00);
        wr(8'h17, 8'h8a);
        rd_is(8'h17, 8'h8a);
        // Unlatched motion on X: boundary, polarity, live flags.
        wr(8'h15, 8'h48);
        sample(12'sd175, 12'sd0, 12'sd0);
        rd_is(8'h16, 8'h00);
        sample(12'sd176, 12'sd0, 12'sd0);
        rd_is(8'h16, 8'h82);
        sample(-12'sd2047, 12'sd0, 12'sd0);
        rd_is(8'h16, 8'h83);
        rd_is(8'h16, 8'h83);
        check("irq", 8'h02, {6'h00, irq1_w, irq2_w});
        sample(12'sd0, 12'sd0, 12'sd0);
        rd_is(8'h16, 8'h00);
        // Freefall ANDs the enabled axes; one high axis ends it.
        wr(8'h15, 8'h38);
        sample(12'sd160, -12'sd160, 12'sd160);
        rd_is(8'h16, 8'h80);
        sample(12'sd176, 12'sd160, 12'sd160);
        rd_is(8'h16, 8'h02);
        // Motion with only Y enabled ignores X.
        wr(8'h15, 8'h50);
        sample(12'sd2047, 12'sd0, 12'sd0);
        rd_is(8'h16, 8'h00);
        // Debounce count 3, decrement mode then clear mode.
        dcount = 8'h03;
        wr(8'h15, 8'h48);
        wr(8'h17, 8'h0a);
        repeat (2) sample(12'sd2047, 12'sd0, 12'sd0);
        ea_is(1'b0);
        sample(12'sd2047, 12'sd0, 12'sd0);
        ea_is(1'b1);
        repeat (2) sample(12'sd0, 12'sd0, 12'sd0);
        ea_is(1'b1);
        sample(12'sd0, 12'sd0, 12'sd0);
        ea_is(1'b0);
        wr(8'h17, 8'h8a);
        repeat (3) sample(12'sd2047, 12'sd0, 12'sd0);
        ea_is(1'b1);
        sample(12'sd0, 12'sd0, 12'sd0);
        ea_is(1'b0);
        repeat (2) sample(12'sd2047, 12'sd0, 12'sd0);
        ea_is(1'b0);
        sample(12'sd2047, 12'sd0, 12'sd0);
        ea_is(1'b1);
        sample(12'sd0, 12'sd0, 12'sd0);
        // Latched motion on X and Y.
        dcount = 8'h00;
        wr(8'h15, 8'hd8);
        sample(-12'sd2047, 12'sd0, 12'sd0);
        sample(12'sd0, 12'sd2047, 12'sd0);
        rd_is(8'h16, 8'h83);
        ea_is(1'b0);
        rd_is(8'h16, 8'h00);
        sample(12'sd0, 12'sd2047, 12'sd0);
        rd_is(8'h16, 8'h88);
        irq_route = 1'b0;
        sample(12'sd0, 12'sd2047, 12'sd0);
        ea_is(1'b1);
        check("irq", 8'h01, {6'h00, irq1_w, irq2_w});
        wr(8'h15, 8'h00);
        repeat (2) @(posedge clk_sys_in);
        #1;
        ea_is(1'b0);
        results();
    end
endmodule : test_freefall_motion_detector
